// ===== logic/lcd_cmd_decoder.sv
// Operation
// - Deep sleep entered when gate falls with select low and code bits 1,1,0.
// - Deep sleep loses array contents and disables buffers except the gate input.
// - In deep sleep only the gate input is watched; all else ignored.
// - After deep sleep, operation resumes only after full reinitialization.
// - Commands accepted only after two clocks plus power-down exit time.
// - Idle in cycle N valid only when gate equal in N-1 and N.
// - Idle decoded from select high, or select low with bits 0-2 high.
// - Idle never aborts an operation already in progress.
// - Any illegal event forces reinitialization; power-down is not entered.
// - Mode write: address 0-5 rising, address 6-7 and operand falling.
// - Activate: row 8-12 and bank rising, row 0-7,13,14 falling.
// - Commands decoded on rising edge; second-phase bits on falling edge.
// - Ordinary power-down entered when gate falls with select high.
`timescale 1ns/1ns
`include "lcd_params.svh"

module lcd_cmd_decoder #(
    parameter int XP_CYCLES  = `LCD_XP_CYCLES,
    parameter int MRW_CYCLES = `LCD_MRW_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         link_clk,
    input  wire logic         cke,
    input  wire logic         cs_n,
    input  wire logic [9:0]   cmd_addr_bus,
    input  wire logic         init_start,
    output logic              input_buf_en,
    output logic              array_valid,
    output logic              cmd_valid,
    output lcd_pkg::lcd_cmd_t cmd_kind,
    output logic [7:0]        mode_reg_addr,
    output logic [7:0]        mode_reg_operand,
    output logic [14:0]       row_addr,
    output logic [2:0]        bank_addr,
    output logic              deep_sleep_mode,
    output logic              power_down,
    output logic              init_required
);
    import lcd_pkg::*;

    localparam logic [3:0] SETTLE_TOTAL = 4'(`LCD_SETTLE_CLOCKS + XP_CYCLES);
    localparam logic [3:0] MRW_LOAD     = 4'(MRW_CYCLES);

    // =========================================================================
    // Rising-edge command decode, shared by the link state machine.
    function automatic lcd_cmd_t decode_steady(input logic sel_n, input logic [9:0] ca);
        lcd_cmd_t k;
        k = LCD_K_OTHER;
        if (sel_n || ca[2:0] == `LCD_CA_IDLE) begin
            k = LCD_K_NONE;
        end else if (ca[3:0] == `LCD_CA_MRW) begin
            k = LCD_K_MRW;
        end else if (ca[1:0] == `LCD_CA_ACTIVATE) begin
            k = LCD_K_ACT;
        end
        return k;
    endfunction

    // =========================================================================
    // Link domain: second-phase capture on the falling edge.
    logic [9:0] fall_ca;

    // The falling half of a command is parked here until the next rising edge.
    always_ff @(negedge link_clk or negedge rstn) begin
        if (!rstn) begin
            fall_ca <= 10'h000;
        end else begin
            fall_ca <= cmd_addr_bus;
        end
    end

    // Init restart request from the core, carried as a toggle.
    logic init_tgl;
    logic init_s1;
    logic init_s2;
    logic init_s3;
    logic init_seen;

    // The first stage feeds only the second; the edge is taken from later stages.
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            init_s1 <= 1'b0;
            init_s2 <= 1'b0;
            init_s3 <= 1'b0;
        end else begin
            init_s1 <= init_tgl;
            init_s2 <= init_s1;
            init_s3 <= init_s2;
        end
    end
    assign init_seen = init_s2 ^ init_s3;

    // =========================================================================
    // Link domain state machine.
    lcd_state_t state;
    lcd_state_t next_state;
    logic       cke_prev;
    logic       next_cke_prev;
    logic [3:0] settle;
    logic [3:0] next_settle;
    logic [3:0] mrw_busy;
    logic [3:0] next_mrw_busy;
    logic       after_entry;
    logic       next_after_entry;
    lcd_cmd_t   pend_kind;
    lcd_cmd_t   next_pend_kind;
    logic [9:0] pend_ca;
    logic [9:0] next_pend_ca;
    logic       evt_tgl;
    logic       next_evt_tgl;
    lcd_cmd_t   evt_kind;
    lcd_cmd_t   next_evt_kind;
    logic [7:0] evt_addr;
    logic [7:0] next_evt_addr;
    logic [7:0] evt_oper;
    logic [7:0] next_evt_oper;
    logic [14:0] evt_row;
    logic [14:0] next_evt_row;
    logic [2:0] evt_bank;
    logic [2:0] next_evt_bank;
    logic [2:0] st_flags;
    logic [2:0] next_st_flags;
    lcd_cmd_t   steady_kind;
    logic       is_idle;

    assign steady_kind = decode_steady(cs_n, cmd_addr_bus);
    assign is_idle     = (steady_kind == LCD_K_NONE);
    // Core-facing state levels come from flops, so no decode glitch reaches a synchroniser.
    assign next_st_flags = {next_state == LCD_ST_NEED_INIT, next_state == LCD_ST_PWRDN, next_state == LCD_ST_DEEP};

    // Next-state logic; an illegal event always ends in the reinit state.
    always_comb begin
        next_state       = state;
        next_cke_prev    = cke;
        next_settle      = (settle != 4'h0) ? settle - 4'h1 : 4'h0;
        next_mrw_busy    = (mrw_busy != 4'h0) ? mrw_busy - 4'h1 : 4'h0;
        next_after_entry = 1'b0;
        next_pend_kind   = LCD_K_NONE;
        next_pend_ca     = cmd_addr_bus;
        unique case (state)
            LCD_ST_ACTIVE: begin
                if (cke_prev && !cke) begin
                    if (mrw_busy != 4'h0) begin
                        next_pend_kind = LCD_K_ILLEGAL;
                    end else if (!cs_n && cmd_addr_bus[2:0] == `LCD_CA_DEEP_ENTRY) begin
                        next_pend_kind = LCD_K_DEEP_ENTRY;
                        next_state     = LCD_ST_DEEP;
                    end else if (cs_n || cmd_addr_bus[2:0] == `LCD_CA_SELF_REFRESH) begin
                        next_pend_kind   = LCD_K_PD_ENTRY;
                        next_state       = LCD_ST_PWRDN;
                        next_after_entry = 1'b1;
                    end else begin
                        next_pend_kind = LCD_K_ILLEGAL;
                    end
                end else if (!cke_prev || !cke) begin
                    next_pend_kind = LCD_K_ILLEGAL;
                end else if (!is_idle) begin
                    // Idle needs the gate steady over two edges, checked above.
                    if (settle != 4'h0) begin
                        next_pend_kind = LCD_K_ILLEGAL;
                    end else begin
                        next_pend_kind = steady_kind;
                        if (steady_kind == LCD_K_MRW) begin
                            next_mrw_busy = MRW_LOAD;
                        end
                    end
                end
                if (next_pend_kind == LCD_K_ILLEGAL) begin
                    next_state = LCD_ST_NEED_INIT;
                end
            end
            LCD_ST_PWRDN: begin
                if (after_entry && !cs_n && cmd_addr_bus[2:0] != `LCD_CA_IDLE) begin
                    next_pend_kind = LCD_K_ILLEGAL;
                    next_state     = LCD_ST_NEED_INIT;
                end else if (cke && cs_n) begin
                    next_pend_kind = LCD_K_PD_EXIT;
                    next_state     = LCD_ST_ACTIVE;
                    next_settle    = SETTLE_TOTAL;
                end else if (cke) begin
                    next_pend_kind = LCD_K_ILLEGAL;
                    next_state     = LCD_ST_NEED_INIT;
                end
            end
            LCD_ST_DEEP: begin
                // Only the gate input matters here.
                if (cke) begin
                    next_state = LCD_ST_NEED_INIT;
                end
            end
            LCD_ST_NEED_INIT: begin
                if (init_seen && cke) begin
                    next_state = LCD_ST_ACTIVE;
                end
            end
        endcase
    end

    // Event word for the core, assembled one edge later so the falling half is in.
    always_comb begin
        next_evt_tgl  = evt_tgl;
        next_evt_kind = evt_kind;
        next_evt_addr = evt_addr;
        next_evt_oper = evt_oper;
        next_evt_row  = evt_row;
        next_evt_bank = evt_bank;
        if (pend_kind != LCD_K_NONE) begin
            next_evt_tgl  = ~evt_tgl;
            next_evt_kind = pend_kind;
            next_evt_addr = {fall_ca[1:0], pend_ca[9:4]};
            next_evt_oper = fall_ca[9:2];
            next_evt_row  = {fall_ca[9:8], pend_ca[6:2], fall_ca[7:0]};
            next_evt_bank = pend_ca[9:7];
        end
    end

    // Link registers only; reset lands in the reinit state.
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            state       <= LCD_ST_NEED_INIT;
            cke_prev    <= 1'b0;
            settle      <= 4'h0;
            mrw_busy    <= 4'h0;
            after_entry <= 1'b0;
            pend_kind   <= LCD_K_NONE;
            pend_ca     <= 10'h000;
            evt_tgl     <= 1'b0;
            evt_kind    <= LCD_K_NONE;
            evt_addr    <= 8'h00;
            evt_oper    <= 8'h00;
            evt_row     <= 15'h0000;
            evt_bank    <= 3'h0;
            st_flags    <= 3'h4;
        end else begin
            state       <= next_state;
            cke_prev    <= next_cke_prev;
            settle      <= next_settle;
            mrw_busy    <= next_mrw_busy;
            after_entry <= next_after_entry;
            pend_kind   <= next_pend_kind;
            pend_ca     <= next_pend_ca;
            evt_tgl     <= next_evt_tgl;
            evt_kind    <= next_evt_kind;
            evt_addr    <= next_evt_addr;
            evt_oper    <= next_evt_oper;
            evt_row     <= next_evt_row;
            evt_bank    <= next_evt_bank;
            st_flags    <= next_st_flags;
        end
    end

    // Buffers and array contents drop with deep sleep.
    assign input_buf_en = (state != LCD_ST_DEEP);
    assign array_valid  = (state == LCD_ST_ACTIVE) || (state == LCD_ST_PWRDN);

    // =========================================================================
    // Core domain: init toggle, event capture and status synchronisers.
    logic       next_init_tgl;
    logic [2:0] evt_sync;
    logic [1:0] deep_sync;
    logic [1:0] pd_sync;
    logic [1:0] ini_sync;
    logic       next_cmd_valid;
    logic       evt_new;

    // The event word is held for a full link period, far longer than the
    // three core cycles the toggle needs, so it is stable when sampled.
    assign evt_new        = evt_sync[2] ^ evt_sync[1];
    assign next_init_tgl  = init_tgl ^ init_start;
    assign next_cmd_valid = evt_new;

    // Core registers only.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            init_tgl         <= 1'b0;
            evt_sync         <= 3'h0;
            deep_sync        <= 2'h0;
            pd_sync          <= 2'h0;
            ini_sync         <= 2'h3;
            cmd_valid        <= 1'b0;
            cmd_kind         <= LCD_K_NONE;
            mode_reg_addr    <= 8'h00;
            mode_reg_operand <= 8'h00;
            row_addr         <= 15'h0000;
            bank_addr        <= 3'h0;
        end else begin
            init_tgl  <= next_init_tgl;
            evt_sync  <= {evt_sync[1:0], evt_tgl};
            deep_sync <= {deep_sync[0], st_flags[0]};
            pd_sync   <= {pd_sync[0], st_flags[1]};
            ini_sync  <= {ini_sync[0], st_flags[2]};
            cmd_valid <= next_cmd_valid;
            if (evt_new) begin
                cmd_kind         <= evt_kind;
                mode_reg_addr    <= evt_addr;
                mode_reg_operand <= evt_oper;
                row_addr         <= evt_row;
                bank_addr        <= evt_bank;
            end
        end
    end
    assign deep_sleep_mode = deep_sync[1];
    assign power_down      = pd_sync[1];
    assign init_required   = ini_sync[1];

    // =========================================================================
    // Checks on the link domain.
    sequence s_deep_entry;
        state == LCD_ST_ACTIVE && cke_prev && !cke && !cs_n && mrw_busy == 4'h0
            && cmd_addr_bus[2:0] == `LCD_CA_DEEP_ENTRY;
    endsequence

    sequence s_pd_exit;
        state == LCD_ST_PWRDN && !after_entry && cke && cs_n;
    endsequence

    a_deep_entry: assert property (@(posedge link_clk) disable iff (!rstn)
        s_deep_entry |=> state == LCD_ST_DEEP ##1 evt_kind == LCD_K_DEEP_ENTRY)
        else $error("Deep sleep entry not taken.");
    a_deep_hold: assert property (@(posedge link_clk) disable iff (!rstn)
        state == LCD_ST_DEEP && !cke |=> state == LCD_ST_DEEP && pend_kind == LCD_K_NONE)
        else $error("Deep sleep left without gate rising.");
    a_deep_exit: assert property (@(posedge link_clk) disable iff (!rstn)
        state == LCD_ST_DEEP && cke |=> state == LCD_ST_NEED_INIT && !input_buf_en == 1'b0)
        else $error("Deep sleep exit did not request reinit.");
    a_init_block: assert property (@(posedge link_clk) disable iff (!rstn)
        state == LCD_ST_NEED_INIT && !init_seen |=> state == LCD_ST_NEED_INIT && pend_kind == LCD_K_NONE)
        else $error("Decode resumed without init restart.");
    a_buf_off: assert property (@(posedge link_clk) disable iff (!rstn)
        state == LCD_ST_DEEP |-> !input_buf_en && !array_valid)
        else $error("Buffers enabled in deep sleep.");
    a_idle_quiet: assert property (@(posedge link_clk) disable iff (!rstn)
        state == LCD_ST_ACTIVE && cke_prev && cke && (cs_n || cmd_addr_bus[2:0] == 3'h7)
        |=> pend_kind == LCD_K_NONE)
        else $error("Idle decoded as a command.");
    a_idle_keeps: assert property (@(posedge link_clk) disable iff (!rstn)
        state == LCD_ST_ACTIVE && mrw_busy > 4'h1 && cke && is_idle |=> mrw_busy == $past(mrw_busy) - 4'h1)
        else $error("Idle disturbed a running mode write.");
    a_illegal_init: assert property (@(posedge link_clk) disable iff (!rstn)
        pend_kind == LCD_K_ILLEGAL |-> state == LCD_ST_NEED_INIT)
        else $error("Illegal event did not force reinit.");
    a_settle: assert property (@(posedge link_clk) disable iff (!rstn)
        s_pd_exit |=> settle == SETTLE_TOTAL ##1 settle == SETTLE_TOTAL - 4'h1)
        else $error("Exit settle count not loaded.");
    a_mrw_fields: assert property (@(posedge link_clk) disable iff (!rstn)
        pend_kind == LCD_K_MRW |=> evt_addr == {$past(fall_ca[1:0]), $past(pend_ca[9:4])}
            && evt_oper == $past(fall_ca[9:2]))
        else $error("Mode write fields misassembled.");
    a_pd_entry: assert property (@(posedge link_clk) disable iff (!rstn)
        state == LCD_ST_ACTIVE && cke_prev && !cke && cs_n && mrw_busy == 4'h0 |=> state == LCD_ST_PWRDN)
        else $error("Power-down entry not taken.");

endmodule

// ===== logic/lcd_params.svh
`ifndef LCD_PARAMS_SVH
`define LCD_PARAMS_SVH

// =============================================================================
// Command encodings seen on the rising edge, as {bit2, bit1, bit0}.
`define LCD_CA_DEEP_ENTRY   3'h3
`define LCD_CA_SELF_REFRESH 3'h4
`define LCD_CA_IDLE         3'h7
// Mode register write uses bits 3..0, activate uses bits 1..0.
`define LCD_CA_MRW          4'h0
`define LCD_CA_ACTIVATE     2'h2

// =============================================================================
// Timing counts in link clock cycles.
`define LCD_SETTLE_CLOCKS   2
`define LCD_XP_CYCLES       3
`define LCD_MRW_CYCLES      5

`endif

// ===== logic/lcd_pkg.sv
package lcd_pkg;

    // Link side operating state of the command decoder.
    typedef enum logic [1:0] {
        LCD_ST_ACTIVE,
        LCD_ST_PWRDN,
        LCD_ST_DEEP,
        LCD_ST_NEED_INIT
    } lcd_state_t;

    // Kind of event reported to the core side.
    typedef enum logic [2:0] {
        LCD_K_NONE,
        LCD_K_MRW,
        LCD_K_ACT,
        LCD_K_OTHER,
        LCD_K_PD_ENTRY,
        LCD_K_DEEP_ENTRY,
        LCD_K_PD_EXIT,
        LCD_K_ILLEGAL
    } lcd_cmd_t;

endpackage

// ===== tb/lcd_ctrl_model.sv
`timescale 1ns/1ns
// =====================================================================
// Controller model: makes the link clock and drives the command lines.
module lcd_ctrl_model (
    output logic       link_clk,
    output logic       cke,
    output logic       cs_n,
    output logic [9:0] cmd_addr_bus
);
    logic clk_run;

    // The clock runs at a steady period, so every cycle is clean.
    // A stop parks the true line low at its next falling half.
    initial begin
        link_clk = 1'b0;
        clk_run = 1'b1;
        cke = 1'b1;
        cs_n = 1'b1;
        cmd_addr_bus = 10'h000;
        #13;
        forever begin
            if (clk_run || link_clk) begin
                link_clk = ~link_clk;
            end
            #80;
        end
    end

    // Stops the clock for a span, then lets it resume on the same grid.
    task automatic stop_clk(input int span);
        clk_run = 1'b0;
        #(span);
        clk_run = 1'b1;
    endtask

    // One command, then a deselect cycle at the same gate level.
    // The deselected bus shows a flipped pattern, so stale values are never read as valid.
    task automatic cmd(input logic k, input logic c, input logic [9:0] r, input logic [9:0] f);
        @(negedge link_clk);
        #1;
        cke = k;
        cs_n = c;
        cmd_addr_bus = r;
        @(posedge link_clk);
        #1;
        cmd_addr_bus = f;
        @(negedge link_clk);
        #1;
        cs_n = 1'b1;
        cmd_addr_bus = ~f;
    endtask
endmodule

// ===== tb/test_lcd_cmd_decoder.sv
`timescale 1ns/1ns
// =====================================================================
// Bench for the command decoder with the controller model on the link.
module test_lcd_cmd_decoder;
    import lcd_pkg::*;
    localparam int XP  = 3;
    localparam int MODE_REG_WRITE_CMD = 5;
    logic        clk;
    logic        rstn;
    logic        init_start;
    logic        link_clk;
    logic        cke;
    logic        cs_n;
    logic [9:0]  cmd_addr_bus;
    logic        input_buf_en;
    logic        array_valid;
    logic        cmd_valid;
    lcd_cmd_t    cmd_kind;
    logic [7:0]  mode_reg_addr;
    logic [7:0]  mode_reg_operand;
    logic [14:0] row_addr;
    logic [2:0]  bank_addr;
    logic        deep_sleep_mode;
    logic        power_down;
    logic        init_required;
    int          error_cnt;
    int          check_count;
    int          evt_n;

    lcd_cmd_decoder #(.XP_CYCLES(XP), .MRW_CYCLES(MODE_REG_WRITE_CMD)) i_lcd_cmd_decoder (
        .clk(clk), .rstn(rstn), .link_clk(link_clk), .cke(cke), .cs_n(cs_n),
        .cmd_addr_bus(cmd_addr_bus), .init_start(init_start), .input_buf_en(input_buf_en),
        .array_valid(array_valid), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind),
        .mode_reg_addr(mode_reg_addr), .mode_reg_operand(mode_reg_operand), .row_addr(row_addr),
        .bank_addr(bank_addr), .deep_sleep_mode(deep_sleep_mode), .power_down(power_down),
        .init_required(init_required));
    lcd_ctrl_model i_lcd_ctrl_model (.link_clk(link_clk), .cke(cke), .cs_n(cs_n), .cmd_addr_bus(cmd_addr_bus));

    // Core clock and a count of event pulses, so a pulse is never missed between tasks.
    always #5 clk = ~clk;
    always @(posedge clk) begin
        if (cmd_valid === 1'b1) begin
            evt_n <= evt_n + 1;
        end
    end

    // =====================================================================
    // Shared tasks.
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            error_cnt++;
            $display("BAD %0t %s", $time, m);
        end
    endtask

    task automatic conclude();
        if (error_cnt == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic send(input logic k, input logic c, input logic [9:0] r, input logic [9:0] f);
        i_lcd_ctrl_model.cmd(k, c, r, f);
    endtask

    task automatic mode_reg_write_cmd(input logic [7:0] a, input logic [7:0] o);
        send(1'b1, 1'b0, {a[5:0], 4'h0}, {o, a[7:6]});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask

    // Bounded wait for the next event pulse, then its kind is judged.
    task automatic wait_evt(input int n0, input lcd_cmd_t k);
        int i;
        i = 0;
        while (evt_n == n0 && i < 200) begin
            @(posedge clk);
            #1;
            i++;
        end
        chk(evt_n != n0 && cmd_kind === k, "event kind");
    endtask

    // =====================================================================
    // Scenarios.
    task automatic t_init();
        int i;
        send(1'b1, 1'b1, 10'h000, 10'h000);
        @(posedge clk);
        #1;
        init_start = 1'b1;
        @(posedge clk);
        #1;
        init_start = 1'b0;
        i = 0;
        while (init_required !== 1'b0 && i < 400) begin
            @(posedge clk);
            i++;
        end
        idle(2);
        chk(init_required === 1'b0 && array_valid === 1'b1 && input_buf_en === 1'b1, "init");
    endtask

    task automatic t_mode_write(input logic [7:0] a, input logic [7:0] o);
        int n0;
        n0 = evt_n;
        mode_reg_write_cmd(a, o);
        wait_evt(n0, LCD_K_MRW);
        chk(mode_reg_addr === a && mode_reg_operand === o, "mode write fields");
    endtask

    task automatic t_activate();
        int n0;
        n0 = evt_n;
        send(1'b1, 1'b1, 10'h155, 10'h2aa);
        send(1'b1, 1'b0, 10'h3f7, 10'h0c3);
        idle(4);
        chk(evt_n == n0, "idle made an event");
        i_lcd_ctrl_model.stop_clk(800);
        idle(XP + 3);
        chk(evt_n == n0 && power_down === 1'b0 && array_valid === 1'b1, "clock stop with gate high");
        send(1'b1, 1'b0, {3'h6, 5'h0b, 2'h2}, {2'h3, 8'h2d});
        wait_evt(n0, LCD_K_ACT);
        chk(row_addr === 15'h6b2d && bank_addr === 3'h6, "activate fields");
        n0 = evt_n;
        send(1'b1, 1'b0, 10'h00c, 10'h000);
        wait_evt(n0, LCD_K_OTHER);
    endtask

    task automatic t_power_down();
        int n0;
        n0 = evt_n;
        send(1'b0, 1'b1, 10'h000, 10'h3ff);
        wait_evt(n0, LCD_K_PD_ENTRY);
        idle(1);
        chk(power_down === 1'b1 && array_valid === 1'b1, "power-down state");
        idle(2);
        i_lcd_ctrl_model.stop_clk(1000);
        idle(2);
        chk(evt_n == n0 + 1 && power_down === 1'b1, "clock stop in power-down");
        n0 = evt_n;
        send(1'b1, 1'b1, 10'h000, 10'h000);
        wait_evt(n0, LCD_K_PD_EXIT);
        idle(XP + 3);
        t_mode_write(8'h0f, 8'hf0);
        chk(power_down === 1'b0, "power-down stuck");
    endtask

    // A command too soon after wake-up, then a gate drop during a mode write.
    task automatic t_illegal_timing();
        idle(MODE_REG_WRITE_CMD);
        send(1'b0, 1'b1, 10'h000, 10'h000);
        idle(2);
        send(1'b1, 1'b1, 10'h000, 10'h000);
        mode_reg_write_cmd(8'h11, 8'h22);
        idle(4);
        chk(cmd_kind === LCD_K_ILLEGAL && init_required === 1'b1, "early command");
        t_init();
        mode_reg_write_cmd(8'h12, 8'h34);
        send(1'b0, 1'b1, 10'h000, 10'h000);
        idle(4);
        chk(cmd_kind === LCD_K_ILLEGAL && init_required === 1'b1, "gate drop in write");
        t_init();
    endtask

    task automatic t_deep();
        int n0;
        n0 = evt_n;
        send(1'b0, 1'b0, 10'h2a3, 10'h155);
        wait_evt(n0, LCD_K_DEEP_ENTRY);
        idle(1);
        chk(deep_sleep_mode === 1'b1 && input_buf_en === 1'b0 && array_valid === 1'b0, "deep");
        n0 = evt_n;
        send(1'b0, 1'b0, 10'h000, 10'h3ff);
        send(1'b0, 1'b0, 10'h07e, 10'h0ff);
        idle(2);
        chk(evt_n == n0, "input seen in deep sleep");
        send(1'b1, 1'b1, 10'h000, 10'h000);
        idle(4);
        n0 = evt_n;
        mode_reg_write_cmd(8'h33, 8'h44);
        idle(4);
        chk(evt_n == n0 && init_required === 1'b1 && deep_sleep_mode === 1'b0, "no reinit");
        t_init();
        t_mode_write(8'h33, 8'h44);
    endtask

    task automatic t_bad_entry();
        int n0;
        idle(MODE_REG_WRITE_CMD);
        n0 = evt_n;
        send(1'b0, 1'b0, 10'h004, 10'h000);
        wait_evt(n0, LCD_K_PD_ENTRY);
        send(1'b1, 1'b1, 10'h000, 10'h000);
        idle(XP + 3);
        n0 = evt_n;
        send(1'b0, 1'b0, 10'h000, 10'h000);
        wait_evt(n0, LCD_K_ILLEGAL);
        idle(1);
        chk(init_required === 1'b1, "illegal entry kept going");
        t_init();
    endtask

    // =====================================================================
    // Main sequence and watchdog.
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        init_start = 1'b0;
        error_cnt = 0;
        check_count = 0;
        evt_n = 0;
        repeat (10) @(posedge clk);
        chk(init_required === 1'b1 && cmd_valid === 1'b0 && cmd_kind === LCD_K_NONE, "reset");
        #1;
        rstn = 1'b1;
        t_init();
        t_mode_write(8'ha5, 8'h3c);
        t_mode_write(8'h5a, 8'hc3);
        t_activate();
        t_power_down();
        t_illegal_timing();
        t_deep();
        t_bad_entry();
        conclude();
    end

    initial begin
        #400000;
        error_cnt++;
        conclude();
    end
endmodule
